//--- sim/tsq_regs_tb.sv
// Purpose: self-checking bench for the step pointer and step queue registers
// Assumes: one ahb-lite master, hready taken from the slave's hreadyout
// Notes:   bus tasks never assume a latency, the watchdog cuts any hang
`timescale 1ns/100ps
module tsq_regs_tb;
    logic        ref_clk      = 1'h0;
    logic        rstn         = 1'h0;
    logic        hsel         = 1'h0;
    logic [31:0] haddr        = 32'h0;
    logic [1:0]  htrans       = 2'h0;
    logic        hwrite       = 1'h0;
    logic [2:0]  hsize        = 3'h2;
    logic [31:0] hwdata       = 32'h0;
    logic        step_advance = 1'h0;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic [4:0]  step_pointer;
    logic [7:0]  step_command;
    logic        sequencer_enable;
    logic        sequencer_run;
    logic [31:0] rd;
    int          errors       = 0;
    int          check_count  = 0;

    always #5 ref_clk = ~ref_clk;

    tsq_regs i_tsq_regs (.ref_clk(ref_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .step_advance(step_advance), .step_pointer(step_pointer),
        .step_command(step_command), .sequencer_enable(sequencer_enable),
        .sequencer_run(sequencer_run));

    // distinct byte per step so a swapped half or word shows up
    function automatic logic [15:0] qw(input int x);
        return {4'hA, 4'(2 * x + 1), 4'h5, 4'(2 * x)};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        hsel   <= 1'h1;
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge ref_clk); while (hreadyout !== 1'h1);
        hsel   <= 1'h0;
        htrans <= 2'h0;
        if (wr) hwdata <= d;
        do @(posedge ref_clk); while (hreadyout !== 1'h1);
        rd = hrdata;
        chk({31'h0, hresp}, 32'h0);
    endtask

    task automatic do_reset;
        rstn <= 1'h0;
        repeat (20) @(posedge ref_clk);
        rstn <= 1'h1;
    endtask

    // pulse one advance, then look at pointer and, an edge later, the command
    task automatic advance(input logic [4:0] p, input logic [7:0] c);
        @(posedge ref_clk);
        step_advance <= 1'h1;
        @(posedge ref_clk);
        step_advance <= 1'h0;
        #1;
        chk({27'h0, step_pointer}, {27'h0, p});
        @(posedge ref_clk);
        #1;
        chk({24'h0, step_command}, {24'h0, c});
    endtask

    task automatic cmd_at(input logic [4:0] p);
        bus(1'h1, 32'h20, {27'h0, p});
        repeat (2) @(posedge ref_clk);
        #1;
        chk({24'h0, step_command}, {24'h0, p[0] ? 4'hA : 4'h5, p[3:0]});
    endtask

    task automatic t_reset_vals;
        bus(1'h0, 32'h20, 32'h0);
        chk(rd, 32'h0);
        bus(1'h0, 32'h24, 32'h0);
        chk(rd, 32'h0);
    endtask

    task automatic t_free_rw;
        bus(1'h1, 32'h20, 32'hFFFF_FFFF);
        bus(1'h0, 32'h20, 32'h0);
        chk(rd, 32'h0000_001F);
        for (int x = 0; x < 8; x++) bus(1'h1, 32'(4 * x), {16'h5A5A, qw(x)});
        for (int x = 0; x < 8; x++) begin
            bus(1'h0, 32'(4 * x), 32'h0);
            chk(rd, {16'h0, qw(x)});
        end
        for (int i = 0; i < 16; i++) cmd_at(5'(i));
        bus(1'h1, 32'h28, 32'h1234_5678);
        bus(1'h0, 32'h28, 32'h0);
        chk(rd, 32'h0);
    endtask

    task automatic t_lock;
        bus(1'h1, 32'h20, 32'h1F);
        advance(5'h1F, 8'h00);
        bus(1'h1, 32'h24, 32'h3);
        #1;
        chk({30'h0, sequencer_run, sequencer_enable}, 32'h3);
        bus(1'h0, 32'h24, 32'h0);
        chk(rd, 32'h3);
        // dropped writes: the lock must hold both the pointer and a queue word
        bus(1'h1, 32'h20, 32'h3);
        bus(1'h1, 32'h00, 32'h0);
        bus(1'h0, 32'h20, 32'h0);
        chk(rd, 32'h1F);
        bus(1'h0, 32'h00, 32'h0);
        chk(rd, {16'h0, qw(0)});
        advance(5'h00, 8'h50);
        bus(1'h1, 32'h24, 32'h0);
        #1;
        chk({30'h0, sequencer_run, sequencer_enable}, 32'h0);
        bus(1'h1, 32'h20, 32'h2);
        bus(1'h0, 32'h20, 32'h0);
        chk(rd, 32'h2);
    endtask

    task automatic t_keep;
        do_reset();
        bus(1'h0, 32'h20, 32'h0);
        chk(rd, 32'h0);
        for (int x = 0; x < 8; x++) begin
            bus(1'h0, 32'(4 * x), 32'h0);
            chk(rd, {16'h0, qw(x)});
        end
    endtask

    task automatic give_verdict;
        $display("errors %0d check_count %0d", errors, check_count);
        if (errors == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // the sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge ref_clk);
        errors++;
        give_verdict();
    end

    initial begin
        do_reset();
        t_reset_vals();
        t_free_rw();
        t_lock();
        t_keep();
        give_verdict();
    end
endmodule

//--- src/tsq_pkg.sv
// Purpose: shared constants and types for the trigger step queue registers
// Assumes: ahb-lite slave, 32-bit data, one aligned word per register
// Notes:   offsets are byte addresses inside the slave window
package tsq_pkg;

    localparam int unsigned QUEUE_WORDS = 8;
    localparam int unsigned PTR_W       = 5;
    localparam int unsigned WORD_W      = 16;
    localparam int unsigned CMD_W       = 8;

    // byte offsets
    localparam logic [7:0] OFS_QUEUE0 = 8'h00;
    localparam logic [7:0] OFS_PTR    = 8'h20;
    localparam logic [7:0] OFS_CTRL   = 8'h24;

    // word indexes (byte offset / 4)
    localparam logic [5:0] IDX_QUEUE_LAST = 6'h07;
    localparam logic [5:0] IDX_PTR        = 6'h08;
    localparam logic [5:0] IDX_CTRL       = 6'h09;

    // field positions
    localparam int unsigned CTRL_EN_BIT  = 0;
    localparam int unsigned CTRL_RUN_BIT = 1;
    localparam int unsigned STEP_ODD_LSB  = 8;
    localparam int unsigned STEP_EVEN_LSB = 0;

    // values after reset
    localparam logic [4:0]  PTR_RST   = 5'h00;
    localparam logic [1:0]  CTRL_RST  = 2'h0;
    localparam logic [7:0]  CMD_RST   = 8'h00;
    localparam logic [31:0] RDATA_RST = 32'h0000_0000;

    // captured address phase, used in the following data phase
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [5:0] idx;
    } tsq_dphase_t;

    localparam tsq_dphase_t DPHASE_RST = '{wr: 1'b0, rd: 1'b0, idx: 6'h00};

endpackage

//--- src/tsq_queue_word.sv
// Purpose: one 16-bit step queue word holding two command bytes
// Assumes: write enable already qualified by the lock
// Notes:   no reset on purpose, contents survive every reset
`timescale 1ns/100ps
module tsq_queue_word #(
    parameter int unsigned WIDTH = tsq_pkg::WORD_W
) (
    input  wire logic             ref_clk,
    input  wire logic             wr_en,
    input  wire logic [WIDTH-1:0] wdata,
    output logic      [WIDTH-1:0] q
);

    logic [WIDTH-1:0] q_ff;

    // no reset term: a reset must never disturb the stored steps
    always_ff @(posedge ref_clk) begin // see RQ7
        if (wr_en) begin
            q_ff <= wdata;
        end
    end

    assign q = q_ff;

endmodule

//--- src/tsq_regs.sv
// Purpose: step pointer and step queue registers of a trigger sequencer
// Assumes: single ahb-lite master, word accesses, zero wait states
// Notes:   step_command lags the pointer by one clock
//
// Decided for this implementation: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/100ps

// Summary of operation
// RQ1: pointer is 5 bits, indexes active step
// RQ2: pointer bits 15 to 5 read zero
// RQ3: enabled and running locks pointer and queue
// RQ4: eight 16-bit queue words, sixteen step bytes
// RQ5: high byte holds odd step 2x+1
// RQ6: low byte holds even step 2x
// RQ7: queue words untouched by any reset
// RQ8: unlocked writes store at once, reads free
module tsq_regs (
    input  wire logic        ref_clk,
    input  wire logic        rstn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [31:0] hrdata,
    input  wire logic        step_advance,
    output logic      [4:0]  step_pointer,
    output logic      [7:0]  step_command,
    output logic             sequencer_enable,
    output logic             sequencer_run
);

    tsq_pkg::tsq_dphase_t dp_ff;
    tsq_pkg::tsq_dphase_t nxt_dp;
    logic [4:0]           ptr_ff;
    logic [4:0]           nxt_ptr;
    logic [1:0]           ctrl_ff;
    logic [1:0]           nxt_ctrl;
    logic [31:0]          hrdata_ff;
    logic [31:0]          nxt_rdata;
    logic [7:0]           cmd_ff;
    logic [7:0]           nxt_cmd;
    logic                 hreadyout_ff;
    logic                 hresp_ff;

    // address phase decode
    wire        addr_take = hsel & htrans[1] & hready;
    wire [5:0]  a_word    = haddr[7:2];
    wire        a_mapped  = (haddr[31:8] == 24'h000000) & (a_word <= tsq_pkg::IDX_CTRL);
    wire        a_rd      = addr_take & ~hwrite & a_mapped;

    assign nxt_dp.wr  = addr_take & hwrite & a_mapped;
    assign nxt_dp.rd  = a_rd;
    assign nxt_dp.idx = a_word;

    // lock while the sequencer executes steps
    wire locked  = ctrl_ff[tsq_pkg::CTRL_EN_BIT] & ctrl_ff[tsq_pkg::CTRL_RUN_BIT]; // see RQ3
    wire wr_ptr  = dp_ff.wr & (dp_ff.idx == tsq_pkg::IDX_PTR) & ~locked; // see RQ3 see RQ8
    wire wr_ctrl = dp_ff.wr & (dp_ff.idx == tsq_pkg::IDX_CTRL);
    wire wr_qany = dp_ff.wr & (dp_ff.idx <= tsq_pkg::IDX_QUEUE_LAST) & ~locked; // see RQ3

    wire [4:0]  wd_ptr  = hwdata[4:0];
    wire [15:0] wd_word = hwdata[15:0];
    wire [4:0]  ptr_inc = ptr_ff + 5'h01;
    wire [2:0]  dp_q_idx = dp_ff.idx[2:0];

    // pointer follows execution while locked, software otherwise
    assign nxt_ptr = wr_ptr ? wd_ptr : ((locked & step_advance) ? ptr_inc : ptr_ff); // see RQ1
    assign nxt_ctrl = wr_ctrl ? hwdata[1:0] : ctrl_ff;

    // queue storage
    logic [15:0]  queue_q   [tsq_pkg::QUEUE_WORDS];
    logic [15:0]  queue_fwd [tsq_pkg::QUEUE_WORDS];
    logic [7:0]   wr_q;
    logic [127:0] queue_flat;

    genvar gi;
    generate
        for (gi = 0; gi < tsq_pkg::QUEUE_WORDS; gi++) begin : g_word
            assign wr_q[gi] = wr_qany & (dp_q_idx == 3'(gi)); // see RQ4
            tsq_queue_word #(
                .WIDTH (tsq_pkg::WORD_W)
            ) u_word ( // see RQ7
                .ref_clk (ref_clk),
                .wr_en   (wr_q[gi]),
                .wdata   (wd_word),
                .q       (queue_q[gi])
            );
            // a read right behind a write sees the new value
            assign queue_fwd[gi] = wr_q[gi] ? wd_word : queue_q[gi];
            assign queue_flat[gi*16 +: 16] = queue_q[gi];
        end
    endgenerate

    // read data is registered so hrdata comes from a flop
    wire [31:0] rd_ptr   = {27'h0, nxt_ptr}; // see RQ2
    wire [31:0] rd_ctrl  = {30'h0, nxt_ctrl};
    wire [31:0] rd_queue = {16'h0000, queue_fwd[a_word[2:0]]}; // see RQ4
    assign nxt_rdata = ~a_rd ? tsq_pkg::RDATA_RST :
                       (a_word == tsq_pkg::IDX_PTR)  ? rd_ptr  :
                       (a_word == tsq_pkg::IDX_CTRL) ? rd_ctrl : rd_queue;

    // active step byte: odd steps in the high byte, even in the low
    wire [15:0] cur_word = queue_q[ptr_ff[3:1]];
    wire [7:0]  cur_hi   = cur_word[tsq_pkg::STEP_ODD_LSB +: 8];  // see RQ5
    wire [7:0]  cur_lo   = cur_word[tsq_pkg::STEP_EVEN_LSB +: 8]; // see RQ6
    // pointer values 16 to 31 have no queue slot and give a zero byte
    assign nxt_cmd = ptr_ff[4] ? tsq_pkg::CMD_RST : (ptr_ff[0] ? cur_hi : cur_lo);

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            dp_ff <= tsq_pkg::DPHASE_RST;
        end else begin
            dp_ff <= nxt_dp;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ptr_ff  <= tsq_pkg::PTR_RST;
            ctrl_ff <= tsq_pkg::CTRL_RST;
        end else begin
            ptr_ff  <= nxt_ptr;
            ctrl_ff <= nxt_ctrl;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            hrdata_ff    <= tsq_pkg::RDATA_RST;
            cmd_ff       <= tsq_pkg::CMD_RST;
            hreadyout_ff <= 1'b1;
            hresp_ff     <= 1'b0;
        end else begin
            hrdata_ff    <= nxt_rdata;
            cmd_ff       <= nxt_cmd;
            hreadyout_ff <= 1'b1;
            hresp_ff     <= 1'b0;
        end
    end

    assign hreadyout        = hreadyout_ff;
    assign hresp            = hresp_ff;
    assign hrdata           = hrdata_ff;
    assign step_pointer     = ptr_ff;
    assign step_command     = cmd_ff;
    assign sequencer_enable = ctrl_ff[tsq_pkg::CTRL_EN_BIT];
    assign sequencer_run    = ctrl_ff[tsq_pkg::CTRL_RUN_BIT];

    // checks
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);

    sequence s_ptr_wr_open;
        dp_ff.wr && (dp_ff.idx == tsq_pkg::IDX_PTR) && !locked;
    endsequence

    sequence s_q_wr_open;
        dp_ff.wr && (dp_ff.idx <= tsq_pkg::IDX_QUEUE_LAST) && !locked;
    endsequence

    a_ptr_upper_zero: assert property ( // see RQ2
        (dp_ff.rd && dp_ff.idx == tsq_pkg::IDX_PTR) |-> (hrdata[31:5] == 27'h0000000)
    ) else $error("pointer read shows upper bits set");

    a_queue_read_word: assert property ( // see RQ4
        (dp_ff.rd && dp_ff.idx <= tsq_pkg::IDX_QUEUE_LAST)
            |-> (hrdata == {16'h0000, queue_q[dp_q_idx]})
    ) else $error("queue read data does not match stored word");

    a_ptr_write_store: assert property ( // see RQ8
        s_ptr_wr_open |=> (step_pointer == $past(wd_ptr))
    ) else $error("unlocked pointer write not stored");

    a_queue_write_store: assert property ( // see RQ8
        s_q_wr_open |=> (queue_q[$past(dp_q_idx)] == $past(wd_word))
    ) else $error("unlocked queue write not stored");

    a_ptr_locked_hold: assert property ( // see RQ3
        (locked && !step_advance) |=> (step_pointer == $past(step_pointer))
    ) else $error("pointer changed while locked");

    a_queue_locked_hold: assert property ( // see RQ3
        locked |=> (queue_flat === $past(queue_flat))
    ) else $error("queue changed while locked");

    a_ptr_step_advance: assert property ( // see RQ1
        (locked && step_advance) |=> (step_pointer == $past(ptr_inc))
    ) else $error("pointer did not follow the executing step");

    a_step_odd_byte: assert property ( // see RQ5
        (!ptr_ff[4] && ptr_ff[0]) |=> (step_command === $past(cur_hi))
    ) else $error("odd step not taken from high byte");

    a_step_even_byte: assert property ( // see RQ6
        (!ptr_ff[4] && !ptr_ff[0]) |=> (step_command === $past(cur_lo))
    ) else $error("even step not taken from low byte");

    // queue words power up unknown, so byte checks above compare identically
    a_ptr_idle_hold: assert property ( // see RQ1
        (!locked && !(dp_ff.wr && dp_ff.idx == tsq_pkg::IDX_PTR))
            |=> (step_pointer == $past(step_pointer))
    ) else $error("pointer moved with no write and no lock");

    a_ptr_read_value: assert property ( // see RQ1
        (dp_ff.rd && dp_ff.idx == tsq_pkg::IDX_PTR) |-> (hrdata[4:0] == step_pointer)
    ) else $error("pointer read differs from pointer");

    a_ctrl_write_store: assert property ( // see RQ3
        (dp_ff.wr && dp_ff.idx == tsq_pkg::IDX_CTRL)
            |=> ({sequencer_run, sequencer_enable} == $past(hwdata[1:0]))
    ) else $error("control write not stored");

    a_idle_rdata_zero: assert property ( // see RQ8
        !dp_ff.rd |-> (hrdata == tsq_pkg::RDATA_RST)
    ) else $error("read data shown outside a read data phase");

    a_ptr_high_cmd: assert property ( // see RQ4
        ptr_ff[4] |=> (step_command == tsq_pkg::CMD_RST)
    ) else $error("pointer past the queue gave a nonzero step");

endmodule
